// >>> trig_params.svh
// Purpose: offsets, reset values and sizes of the trigger match block
// Assumes: 32-bit register width, APB byte addresses
// Notes: included by the package and by every design module that decodes codes
`ifndef TRIG_PARAMS_SVH
`define TRIG_PARAMS_SVH
// register byte offsets
`define REG_CTRL 8'h00
`define REG_CMP 8'h04
`define REG_COUNT 8'h08
`define REG_CAUSE 8'h0c
`define REG_STATUS 8'h10
// reset values
`define CTRL_RST 18'h00000
`define CMP_RST 32'h00000000
`define COUNT_RST 14'h0000
`define CAUSE_RST 6'h00
// trigger type codes
`define TY_NONE 4'h0
`define TY_ADDR 4'h2
`define TY_ICOUNT 4'h3
`define TY_IRQ 4'h4
`define TY_EXC 4'h5
`define TY_XADDR 4'h6
`define TY_EXT 4'h7
// address widths and cache block offset bits
`define VA_W 28
`define PA_W 30
`define BLK_OFS 6
// cache compare options
`define CBO_EVERY 2'h0
`define CBO_BASE 2'h1
`define CBO_RAW 2'h2
`endif

// >>> trig_pkg.sv
// Purpose: types and shared functions of the trigger match block
// Assumes: trig_params.svh gives widths
// Notes: mode codes carry the virtual bit on top
`include "trig_params.svh"
package trig_pkg;
   typedef enum logic [2:0] {
      MODE_U = 3'b000, MODE_S = 3'b001, MODE_M = 3'b011,
      MODE_VU = 3'b100, MODE_VS = 3'b101
   } mode_t;
   typedef enum logic [3:0] {
      ACC_LOAD = 4'h0, ACC_STORE = 4'h1, ACC_EXEC = 4'h2, ACC_LR = 4'h3,
      ACC_SC_OK = 4'h4, ACC_SC_FAIL = 4'h5, ACC_AMO_RD = 4'h6, ACC_AMO_WR = 4'h7,
      ACC_CBO_CLEAN = 4'h8, ACC_CBO_FLUSH = 4'h9, ACC_CBO_INVAL = 4'ha,
      ACC_CBO_ZERO = 4'hb, ACC_PREFETCH = 4'hc, ACC_CBO_HINT = 4'hd
   } acc_kind_t;
   typedef enum logic [1:0] {ST_RUN = 2'b00, ST_HOLD = 2'b01, ST_SQUASH = 2'b10} hold_st_t;
   typedef struct packed {
      mode_t mode;
      logic machine_irq_enable;
      logic kernel_irq_enable;
      logic vsie;
      logic medeleg3;
      logic hedeleg3;
   } hart_state_t;
   typedef struct packed {
      logic valid;
      acc_kind_t kind;
      logic [31:0] addr;
      logic phys;
      logic invalid;
      logic [1:0] size;
      logic [31:0] data;
      logic no_partial;
   } access_t;
   typedef struct packed {
      logic valid;
      logic is_irq;
      logic [4:0] cause;
      mode_t target;
   } trap_t;
   typedef struct packed {
      logic reent;
      logic [1:0] cbo_opt;
      logic select;
      logic [1:0] size;
      logic exec;
      logic store;
      logic load;
      logic action;
      logic vs;
      logic u;
      logic s;
      logic m;
      logic [3:0] ty;
   } ctrl_t;

   // zero-extend physical, sign-extend virtual addresses
   function automatic logic [31:0] widen(input logic [31:0] a, input logic phys);
      if (phys)
         return {{(32-`PA_W){1'b0}}, a[`PA_W-1:0]};
      return {{(32-`VA_W){a[`VA_W-1]}}, a[`VA_W-1:0]};
   endfunction

   // lowest mode a breakpoint raised in from may be taken in
   function automatic mode_t bp_target(input mode_t from, input logic med, input logic hed);
      case (from)
         MODE_S, MODE_U: return med ? MODE_S : MODE_M;
         MODE_VS, MODE_VU: return (med & hed) ? MODE_VS : (med ? MODE_S : MODE_M);
         default: return MODE_M;
      endcase
   endfunction

   // block-maintaining cache operations
   function automatic logic is_cbo(input acc_kind_t k);
      return (k == ACC_CBO_CLEAN) | (k == ACC_CBO_FLUSH) | (k == ACC_CBO_INVAL) |
         (k == ACC_CBO_ZERO);
   endfunction

   // byte-lane merge of an apb write
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] w,
                                         input logic [3:0] b);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++)
         if (b[i])
            r[8*i +: 8] = w[8*i +: 8];
      return r;
   endfunction
endpackage

// >>> trig_mode_gate.sv
// Purpose: decides whether a trigger may fire in a mode and where it traps
// Assumes: hart state sampled the same cycle
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "trig_params.svh"
module trig_mode_gate (
   // evaluation point
   input wire trig_pkg::mode_t at,
   input wire trig_pkg::hart_state_t hs,
   // configuration
   input wire trig_pkg::ctrl_t c,
   input wire logic mte,
   // decision
   output logic allow,
   output trig_pkg::mode_t tgt
);
   import trig_pkg::*;
   wire logic med;
   wire logic en;
   wire logic same;
   wire logic ie_off;
   wire logic ie_block;
   wire logic mte_block;

   // delegation of breakpoints is void under the trap-enable scheme
   assign med = hs.medeleg3 & ~c.reent;
   assign tgt = bp_target(at, med, hs.hedeleg3);
   // mode enable; the virtual supervisor enable exists on every type but plain address triggers (TY_ADDR)
   assign en = (at == MODE_M) ? c.m :
      (at == MODE_S) ? c.s :
      (at == MODE_VS) ? (c.vs & (c.ty != `TY_ADDR)) : c.u;
   // reentrancy: same-mode breakpoints only while interrupts are on; under the trap-enable scheme, machine mode needs mte instead
   assign same = (tgt == at);
   assign ie_off = (at == MODE_M) ? ~hs.machine_irq_enable : (at == MODE_S) ? ~hs.kernel_irq_enable :
      (at == MODE_VS) ? ~hs.vsie : 1'b0;
   assign ie_block = ~c.reent & same & ie_off;
   assign mte_block = c.reent & (at == MODE_M) & ~mte;
   assign allow = en & ~(~c.action & (ie_block | mte_block));
endmodule // trig_mode_gate
`default_nettype wire

// >>> trig_access_match.sv
// Purpose: classifies one memory access and compares it against the trigger
// Assumes: multi-access instructions present each access separately
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "trig_params.svh"
module trig_access_match (
   // access and configuration
   input wire trig_pkg::access_t a,
   input wire trig_pkg::ctrl_t c,
   input wire logic [31:0] cmp,
   // result
   output logic hit
);
   import trig_pkg::*;
   wire logic is_ld;
   wire logic is_st;
   wire logic cbo;
   wire logic kind_ok;
   wire logic cbo_ok;
   wire logic size_ok;
   wire logic [31:0] ea;
   wire logic [31:0] blk;
   wire logic [31:0] cblk;
   wire logic addr_eq;
   wire logic val_eq;
   wire logic addr_ty;

   // load and store classes; failing sc, prefetch and hints are neither
   assign is_ld = (a.kind == ACC_LOAD) | (a.kind == ACC_LR) | (a.kind == ACC_AMO_RD);
   assign cbo = is_cbo(a.kind);
   assign is_st = (a.kind == ACC_STORE) | (a.kind == ACC_SC_OK) | (a.kind == ACC_AMO_WR) | cbo;
   assign kind_ok = (is_ld & c.load) | (is_st & c.store) | ((a.kind == ACC_EXEC) & c.exec);
   // cache operations only see unsized address triggers
   assign cbo_ok = ~cbo | ((c.size == 2'h0) & ~c.select);
   // per-element size, element width or register width for stack pushes
   assign size_ok = (c.size == 2'h0) | (c.size == 2'(a.size + 2'h1));
   // address comparison on the extended address
   assign ea = widen(a.addr, a.phys);
   assign blk = {ea[31:`BLK_OFS], {`BLK_OFS{1'b0}}};
   assign cblk = {cmp[31:`BLK_OFS], {`BLK_OFS{1'b0}}};
   assign addr_eq = ~cbo ? (ea == cmp) :
      (c.cbo_opt == `CBO_EVERY) ? (blk == cblk) :
      (c.cbo_opt == `CBO_BASE) ? (blk == cmp) : (ea == cmp);
   // data compare also applies to amo values
   assign val_eq = c.select ? (a.data == cmp) : addr_eq;
   assign addr_ty = (c.ty == `TY_ADDR) | (c.ty == `TY_XADDR);
   // invalid addresses never match an address compare
   assign hit = a.valid & addr_ty & kind_ok & cbo_ok & size_ok & val_eq &
      ~(a.invalid & ~c.select);
endmodule // trig_access_match
`default_nettype wire

// >>> trig_match_top.sv
// Purpose: native trigger matching and firing policy beside the hart pipeline
// Assumes: hart state, traps and accesses arrive on clk every cycle
// Notes: fire outputs lag their cause by one cycle
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "trig_params.svh"
module trig_match_top (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // hart state and events
   input wire trig_pkg::hart_state_t hs,
   input wire trig_pkg::access_t acc,
   input wire trig_pkg::trap_t trap,
   input wire logic instr_retire,
   input wire logic instr_end,
   input wire logic mret,
   // external trigger pin
   input wire logic ext_trig_pin,
   // results to the hart
   output logic bp_fire,
   output logic dbg_fire,
   output trig_pkg::mode_t bp_mode,
   output logic withhold,
   output logic squash,
   output logic bp_deleg_ok
);
   import trig_pkg::*;
   logic [17:0] ctrl_q;
   logic [31:0] cmp_q;
   logic [13:0] count_q;
   logic [13:0] count_d;
   logic [5:0] cause_q;
   logic mte_q;
   logic mte_d;
   logic mpte_q;
   logic mpte_d;
   logic hit_q;
   logic ext_meta_q;
   logic ext_sync_q;
   logic ext_prev_q;
   hold_st_t st_q;
   hold_st_t st_d;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic bp_fire_q;
   logic dbg_fire_q;
   mode_t bp_mode_q;
   logic withhold_q;
   logic squash_q;
   logic bp_deleg_ok_q;
   ctrl_t c;
   wire logic allow_cur;
   wire logic allow_trap;
   mode_t tgt_cur;
   mode_t tgt_trap;
   wire logic acc_hit;

   assign c = ctrl_t'(ctrl_q);

   // apb decode: answer in the first access cycle
   wire logic setup = psel & ~penable;
   wire logic wr = psel & penable & pready_q & pwrite;
   wire logic sel_ctrl = (paddr == `REG_CTRL);
   wire logic sel_cmp = (paddr == `REG_CMP);
   wire logic sel_cnt = (paddr == `REG_COUNT);
   wire logic sel_cause = (paddr == `REG_CAUSE);
   wire logic sel_stat = (paddr == `REG_STATUS);
   wire logic mapped = sel_ctrl | sel_cmp | sel_cnt | sel_cause | sel_stat;
   wire logic [31:0] ctrl_rd = {12'h000, mpte_q, mte_q, ctrl_q};
   wire logic [31:0] stat_rd = {26'h0000000, ext_sync_q, withhold_q, bp_mode_q, hit_q};
   wire logic [31:0] rd_mux = sel_ctrl ? ctrl_rd :
      sel_cmp ? cmp_q :
      sel_cnt ? {18'h00000, count_q} :
      sel_cause ? {26'h0000000, cause_q} :
      sel_stat ? stat_rd : 32'h00000000;
   wire logic [31:0] wmerge = merge(rd_mux, pwdata, pstrb);

   // mode gating for the current mode and for a trap's handling mode
   trig_mode_gate cur_gate (
      .at(hs.mode),
      .hs(hs),
      .c(c),
      .mte(mte_q),
      .allow(allow_cur),
      .tgt(tgt_cur)
   );
   trig_mode_gate trap_gate (
      .at(trap.target),
      .hs(hs),
      .c(c),
      .mte(mte_q),
      .allow(allow_trap),
      .tgt(tgt_trap)
   );
   trig_access_match acc_match (
      .a(acc),
      .c(c),
      .cmp(cmp_q),
      .hit(acc_hit)
   );

   // external pin synchroniser and rising edge
   wire logic ext_rise = ext_sync_q & ~ext_prev_q;

   // fire sources
   wire logic acc_fire = acc_hit & allow_cur;
   wire logic ic_fire = (c.ty == `TY_ICOUNT) & instr_retire & allow_cur &
      (count_q == 14'h0001);
   wire logic tr_kind = ((c.ty == `TY_EXC) & ~trap.is_irq) | ((c.ty == `TY_IRQ) & trap.is_irq);
   wire logic tr_fire = trap.valid & tr_kind & allow_trap &
      ({trap.is_irq, trap.cause} == cause_q);
   wire logic ex_fire = (c.ty == `TY_EXT) & ext_rise & allow_cur;
   wire logic fire = acc_fire | ic_fire | tr_fire | ex_fire;
   wire mode_t fire_tgt = tr_fire ? tgt_trap : tgt_cur;

   // instruction counter: software write wins over the decrement
   wire logic ic_step = (c.ty == `TY_ICOUNT) & instr_retire & allow_cur & (count_q != 14'h0000);
   assign count_d = (wr & sel_cnt) ? wmerge[13:0] :
      ic_step ? 14'(count_q - 14'h0001) : count_q;

   // trap enable bits: trap into machine saves and clears, return restores
   wire logic m_trap = trap.valid & (trap.target == MODE_M);
   assign mte_d = m_trap ? 1'b0 : mret ? mpte_q :
      (wr & sel_ctrl) ? wmerge[18] : mte_q;
   assign mpte_d = m_trap ? mte_q : (wr & sel_ctrl) ? wmerge[19] : mpte_q;

   // withholding of state changes after a mid-instruction fire
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         ST_RUN: begin
            if (acc_fire & ~instr_end)
               st_d = acc.no_partial ? ST_SQUASH : ST_HOLD;
         end
         ST_HOLD, ST_SQUASH: begin
            if (instr_end)
               st_d = ST_RUN;
         end
         default: st_d = ST_RUN;
      endcase
   end

   // apb answer registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pready_q <= 1'b0;
         prdata_q <= 32'h00000000;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= setup;
         prdata_q <= setup ? rd_mux : prdata_q;
         pslverr_q <= setup & ~mapped;
      end
   end

   // software registers; the compare value keeps every written bit
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= `CTRL_RST;
         cmp_q <= `CMP_RST;
         cause_q <= `CAUSE_RST;
      end else if (wr) begin
         ctrl_q <= sel_ctrl ? wmerge[17:0] : ctrl_q;
         cmp_q <= sel_cmp ? wmerge : cmp_q;
         cause_q <= sel_cause ? wmerge[5:0] : cause_q;
      end
   end

   // counter and trap enable state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_q <= `COUNT_RST;
         mte_q <= 1'b0;
         mpte_q <= 1'b0;
      end else begin
         count_q <= count_d;
         mte_q <= mte_d;
         mpte_q <= mpte_d;
      end
   end

   // sticky hit flag: a new fire beats a write-one clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         hit_q <= 1'b0;
      else
         hit_q <= fire | (hit_q & ~(wr & sel_stat & pstrb[0] & pwdata[0]));
   end

   // external pin: two flops, then edge history
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ext_meta_q <= 1'b0;
         ext_sync_q <= 1'b0;
         ext_prev_q <= 1'b0;
      end else begin
         ext_meta_q <= ext_trig_pin;
         ext_sync_q <= ext_meta_q;
         ext_prev_q <= ext_sync_q;
      end
   end

   // results to the hart
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= ST_RUN;
         bp_fire_q <= 1'b0;
         dbg_fire_q <= 1'b0;
         bp_mode_q <= MODE_M;
         withhold_q <= 1'b0;
         squash_q <= 1'b0;
         bp_deleg_ok_q <= 1'b0;
      end else begin
         st_q <= st_d;
         bp_fire_q <= fire & ~c.action;
         dbg_fire_q <= fire & c.action;
         bp_mode_q <= fire ? fire_tgt : bp_mode_q;
         withhold_q <= (st_d == ST_HOLD);
         squash_q <= (st_d == ST_SQUASH);
         bp_deleg_ok_q <= ~c.reent;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign bp_fire = bp_fire_q;
   assign dbg_fire = dbg_fire_q;
   assign bp_mode = bp_mode_q;
   assign withhold = withhold_q;
   assign squash = squash_q;
   assign bp_deleg_ok = bp_deleg_ok_q;

   // checks on the firing policy
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   m_same_mode_a: assert property (
      fire & (hs.mode == MODE_M) & ~tr_fire |=> bp_mode_q == MODE_M)
      else $error("machine fire not taken in machine mode");
   s_deleg_a: assert property (
      fire & ~tr_fire & (hs.mode == MODE_S) & hs.medeleg3 & ~c.reent
      |=> bp_mode_q == MODE_S)
      else $error("delegated supervisor breakpoint not kept in supervisor");
   vs_both_a: assert property (
      fire & ~tr_fire & (hs.mode == MODE_VS) & ~(hs.medeleg3 & hs.hedeleg3)
      |=> bp_mode_q != MODE_VS)
      else $error("virtual supervisor trap without both delegations");
   icount_end_a: assert property (
      ic_fire & ~(wr & sel_cnt) |=> (count_q == 14'h0000) && (bp_fire_q || dbg_fire_q))
      else $error("instruction count did not fire at zero");
   ie_block_a: assert property (
      (hs.mode == MODE_M) & ~hs.machine_irq_enable & ~c.reent & ~c.action & ~trap.valid |=> ~bp_fire_q)
      else $error("breakpoint in machine mode with interrupts off");
   mte_block_a: assert property (
      c.reent & ~mte_q & ~c.action & (hs.mode == MODE_M) & ~trap.valid |=> ~bp_fire_q)
      else $error("breakpoint in machine mode with trigger enable clear");
   mte_save_a: assert property (
      m_trap |=> ~mte_q && (mpte_q == $past(mte_q)))
      else $error("trap enable not saved on machine trap");
   cbo_size_a: assert property (
      acc.valid & is_cbo(acc.kind) & ((c.size != 2'h0) | c.select) &
      ((c.ty == `TY_ADDR) | (c.ty == `TY_XADDR)) |=> ~(bp_fire_q | dbg_fire_q))
      else $error("cache operation matched a sized or data trigger");
   prefetch_a: assert property (
      acc.valid & ((acc.kind == ACC_PREFETCH) | (acc.kind == ACC_CBO_HINT)) &
      ((c.ty == `TY_ADDR) | (c.ty == `TY_XADDR)) |=> ~(bp_fire_q | dbg_fire_q))
      else $error("prefetch or hint matched a trigger");
   squash_a: assert property (
      (st_q == ST_RUN) & acc_fire & acc.no_partial & ~instr_end
      |=> squash_q ##1 (squash_q || withhold_q || st_q == ST_RUN))
      else $error("mid-instruction fire did not withhold state");
   // register, event and access-class checks
   pready_one_a: assert property (
      setup |=> pready ##1 ~pready)
      else $error("apb answer did not last exactly one cycle");
   cmp_keep_a: assert property (
      wr & sel_cmp & (pstrb == 4'hf) |=> cmp_q == $past(pwdata))
      else $error("compare value lost written bits");
   trap_mode_a: assert property (
      tr_fire & ~c.action & (trap.target == MODE_M) |=> bp_fire_q && (bp_mode_q == MODE_M))
      else $error("trap trigger not raised in the handling mode");
   hold_end_a: assert property (
      (st_q == ST_HOLD) & instr_end |=> ~withhold_q)
      else $error("withholding outlived its instruction");
   invalid_addr_a: assert property (
      acc.valid & acc.invalid & ~c.select & ((c.ty == `TY_ADDR) | (c.ty == `TY_XADDR))
      |=> ~(bp_fire_q | dbg_fire_q))
      else $error("invalid address matched an address trigger");
   fail_sc_a: assert property (
      acc.valid & (acc.kind == ACC_SC_FAIL) & ((c.ty == `TY_ADDR) | (c.ty == `TY_XADDR))
      |=> ~(bp_fire_q | dbg_fire_q))
      else $error("failing store-conditional matched a trigger");
   deleg_off_a: assert property (
      c.reent |=> ~bp_deleg_ok_q)
      else $error("breakpoint delegation not withdrawn under trap-enable scheme");
   ext_edge_a: assert property (
      ext_sync_q & ~ext_prev_q & (c.ty == `TY_EXT) & allow_cur |=> bp_fire_q | dbg_fire_q)
      else $error("external pin edge did not fire");

   // scenarios worth seeing
   trap_fire_c: cover property (tr_fire ##1 bp_fire_q);
   ext_fire_c: cover property (ex_fire ##1 (bp_fire_q || dbg_fire_q));
   hold_c: cover property ((st_q == ST_HOLD) ##[1:8] instr_end);
   dbg_fire_c: cover property (fire & c.action ##1 dbg_fire_q);
   squash_end_c: cover property (squash_q ##1 ~squash_q);
endmodule // trig_match_top
`default_nettype wire

// >>> hart_model.sv
// Purpose: hart model driving privilege state and events into the trigger block
// Assumes: the bench calls its tasks, one at a time
// Notes: each instruction ends three cycles after its access
`timescale 1ns/1ps
`default_nettype none
module hart_model (
   // clock
   input wire logic clk,
   // state and events
   output trig_pkg::hart_state_t hs,
   output trig_pkg::access_t acc,
   output trig_pkg::trap_t trap,
   output logic instr_retire,
   output logic instr_end
);
   import trig_pkg::*;
   // idle: no events, machine mode with interrupts on
   initial begin
      hs = {MODE_M, 5'h10};
      acc = '0;
      trap = '0;
      instr_retire = 1'b0;
      instr_end = 1'b0;
   end
   // mode and enables stand as levels every cycle
   task automatic state(input mode_t m, input logic [4:0] en);
      hs <= {m, en};
   endtask
   // one access pulse, then the instruction ends
   task automatic access(input acc_kind_t k, input logic [31:0] a, input logic [2:0] f);
      @(posedge clk);
      acc <= '{1'b1, k, a, f[2], f[1], 2'h2, a, f[0]};
      @(posedge clk);
      acc.valid <= 1'b0;
      acc.addr <= ~a; // a released address must not look valid
      repeat (2) @(posedge clk);
      instr_end <= 1'b1;
      @(posedge clk);
      instr_end <= 1'b0;
   endtask
   // one retired instruction
   task automatic retire();
      @(posedge clk);
      instr_retire <= 1'b1;
      @(posedge clk);
      instr_retire <= 1'b0;
   endtask
   // trap entry pulse
   task automatic trap_in(input logic [4:0] c, input mode_t t);
      @(posedge clk);
      trap <= '{1'b1, 1'b0, c, t};
      @(posedge clk);
      trap.valid <= 1'b0;
   endtask
endmodule // hart_model
`default_nettype wire

// >>> native_trigger_match_policy_tb.sv
// Purpose: self-checking bench of the trigger matching policy
// Assumes: apb waits for pready, fire one cycle after its cause
// Notes: fires are counted by a monitor and compared per test
`timescale 1ns/1ps
`default_nettype none
module native_trigger_match_policy_tb;
   import trig_pkg::*;
   logic clk, rst, psel, penable, pwrite, ext_trig_pin, mret, ev;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rv;
   logic [3:0] pstrb;
   logic pready, pslverr, bp_fire, dbg_fire, withhold, squash, bp_deleg_ok;
   logic instr_retire, instr_end;
   hart_state_t hs;
   access_t acc;
   trap_t trap;
   mode_t bp_mode;
   int num_errors = 0, checks = 0, fires = 0, holds = 0, sq = 0, cyc = 0, dbgs = 0, f0, h0;
   trig_match_top u_trig_match_top (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .hs(hs), .acc(acc), .trap(trap),
      .instr_retire(instr_retire), .instr_end(instr_end), .mret(mret),
      .ext_trig_pin(ext_trig_pin), .bp_fire(bp_fire), .dbg_fire(dbg_fire),
      .bp_mode(bp_mode), .withhold(withhold), .squash(squash), .bp_deleg_ok(bp_deleg_ok));
   hart_model u_hart_model (.clk(clk), .hs(hs), .acc(acc), .trap(trap),
      .instr_retire(instr_retire), .instr_end(instr_end));
   // clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // monitor of fire and withhold cycles, plus hang limit
   always @(posedge clk) begin
      fires <= fires + int'(bp_fire);
      holds <= holds + int'(withhold);
      sq <= sq + int'(squash);
      dbgs <= dbgs + int'(dbg_fire);
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one apb transfer: setup, then access until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= 4'hf;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rv, ev);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, rv, ev);
      chk(rv, exp);
   endtask
   task automatic since(input int n);
      repeat (6) @(posedge clk);
      chk(32'(fires - f0), 32'(n));
   endtask
   // one access, then the count of fires it caused
   task automatic try(input acc_kind_t k, input logic [31:0] a, input logic [2:0] f, input int n);
      f0 = fires;
      u_hart_model.access(k, a, f);
      since(n);
   endtask
   task automatic mode_is(input mode_t m);
      chk({29'h0, bp_mode}, {29'h0, m});
   endtask
   // main sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata, pstrb, ext_trig_pin, mret} = '0;
      rst = 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rd(8'h04, 32'h0);
      apb(1'b0, 8'h14, 32'h0, rv, ev);
      chk({31'h0, ev}, 32'h1);
      wr(8'h04, 32'hffffffff);
      rd(8'h04, 32'hffffffff);
      wr(8'h04, 32'h00001000);
      rd(8'h10, 32'h00000006);
      chk({31'h0, bp_deleg_ok}, 32'h1);
      $display("test regs done");
      wr(8'h00, 32'h00000212);
      try(ACC_LOAD, 32'h1000, 3'b100, 1);
      mode_is(MODE_M);
      u_hart_model.state(MODE_M, 5'h13);
      try(ACC_LOAD, 32'h1000, 3'b100, 1);
      u_hart_model.state(MODE_M, 5'h00);
      try(ACC_LOAD, 32'h1000, 3'b100, 0);
      wr(8'h00, 32'h00000232);
      u_hart_model.state(MODE_S, 5'h0a);
      try(ACC_LOAD, 32'h1000, 3'b100, 1);
      mode_is(MODE_S);
      u_hart_model.state(MODE_S, 5'h02);
      try(ACC_LOAD, 32'h1000, 3'b100, 0);
      u_hart_model.state(MODE_S, 5'h00);
      try(ACC_LOAD, 32'h1000, 3'b100, 1);
      mode_is(MODE_M);
      wr(8'h00, 32'h00000286);
      u_hart_model.state(MODE_VS, 5'h07);
      try(ACC_LOAD, 32'h1000, 3'b100, 1);
      mode_is(MODE_VS);
      u_hart_model.state(MODE_VS, 5'h03);
      try(ACC_LOAD, 32'h1000, 3'b100, 0);
      u_hart_model.state(MODE_VS, 5'h02);
      try(ACC_LOAD, 32'h1000, 3'b100, 1);
      mode_is(MODE_S);
      $display("test modes done");
      u_hart_model.state(MODE_M, 5'h10);
      wr(8'h00, 32'h00000612);
      for (int k = 0; k < 14; k++) begin
         try(acc_kind_t'(k), 32'h1000, 3'b100, int'((32'h0fdb >> k) & 32'h1));
      end
      for (int o = 0; o < 3; o++) begin
         wr(8'h00, 32'h612 | (32'(o) << 15));
         try(ACC_CBO_CLEAN, 32'h1038, 3'b100, int'(o < 2));
      end
      wr(8'h00, 32'h00003612);
      try(ACC_CBO_ZERO, 32'h1000, 3'b100, 0);
      try(ACC_STORE, 32'h1000, 3'b100, 1);
      wr(8'h00, 32'h00000612);
      try(ACC_LOAD, 32'h1000, 3'b110, 0);
      wr(8'h04, 32'hf8000000);
      rd(8'h04, 32'hf8000000);
      try(ACC_LOAD, 32'h08000000, 3'b000, 1);
      try(ACC_LOAD, 32'h08000000, 3'b100, 0);
      wr(8'h04, 32'h00001000);
      $display("test access kinds done");
      h0 = holds;
      try(ACC_STORE, 32'h1000, 3'b100, 1);
      chk(32'(holds > h0), 32'h1);
      chk({31'h0, withhold}, 32'h0);
      h0 = sq;
      try(ACC_STORE, 32'h1000, 3'b101, 1);
      chk(32'(sq > h0), 32'h1);
      chk({31'h0, squash}, 32'h0);
      $display("test partial done");
      wr(8'h00, 32'h00000013);
      wr(8'h08, 32'h00000001);
      f0 = fires;
      u_hart_model.retire();
      since(1);
      rd(8'h08, 32'h0);
      wr(8'h00, 32'h00000015);
      wr(8'h0c, 32'h00000002);
      f0 = fires;
      u_hart_model.trap_in(5'd2, MODE_M);
      since(1);
      mode_is(MODE_M);
      wr(8'h00, 32'h00000017);
      f0 = fires;
      ext_trig_pin <= 1'b1;
      since(1);
      ext_trig_pin <= 1'b0;
      $display("test events done");
      wr(8'h00, 32'h00020212);
      try(ACC_LOAD, 32'h1000, 3'b100, 0);
      chk({31'h0, bp_deleg_ok}, 32'h0);
      wr(8'h00, 32'h00060212);
      u_hart_model.state(MODE_M, 5'h00);
      try(ACC_LOAD, 32'h1000, 3'b100, 1);
      u_hart_model.trap_in(5'd3, MODE_M);
      rd(8'h00, 32'h000a0212);
      mret <= 1'b1;
      @(posedge clk);
      mret <= 1'b0;
      rd(8'h00, 32'h000e0212);
      wr(8'h00, 32'h00000312);
      try(ACC_LOAD, 32'h1000, 3'b100, 0);
      chk(32'(dbgs), 32'h1);
      $display("test reentrancy done");
      end_of_test();
   end
endmodule // native_trigger_match_policy_tb
`default_nettype wire
